// *** logic/iccf_framer.sv ***
// Correlation header framer with APB control
// Operation
// - First octet version field is zero.
// - Direction flag one for uplink, zero for downlink.
// - Second octet is constant 255 message type.
// - Octets 5-6 hold increasing sequence number, MSB first.
// - Octets 7-8 are zero, octets 9-12 are 255.
// - Octets 13-20 carry the eight-octet correlation number.
// - Correlation joins gateway identifier with four-octet charge identifier.
// - Node flag zero for gateway capture, one for serving node.
// - Exactly one payload unit follows each header.
// - Payload passes unchanged, original header and payload intact.
// - Framed messages go out to the UDP or TCP transport.
// - Transport handles loss; framer only stalls on back-pressure.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module iccf_framer (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Captured packet stream in
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_first,
  input  wire logic        in_last,
  input  wire logic [15:0] in_len,
  input  wire logic        in_dir,
  input  wire logic [31:0] in_charge_id,
  // Framed stream out to transport
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [7:0]  out_data,
  output logic             out_last
);
  iccf_pkg::iccf_state_e state_q;
  logic [4:0]  idx_q;
  logic [15:0] seq_q;
  logic [15:0] len_q;
  logic        dir_q;
  logic [31:0] charge_q;
  logic        en_q;
  logic        ice_q;
  logic [31:0] gw_id_q;
  logic [31:0] count_q;
  logic        seq_wr;
  logic        frame_done;
  logic        hdr_take;
  logic        pay_take;
  logic [7:0]  hdr_octet;
  logic        apb_acc;
  logic        apb_wr;
  logic [7:0]  out_data_d;
  logic        out_last_d;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == iccf_pkg::ADDR_CTRL) || (a == iccf_pkg::ADDR_GWID) ||
                 (a == iccf_pkg::ADDR_SEQ)  || (a == iccf_pkg::ADDR_STAT) ||
                 (a == iccf_pkg::ADDR_COUNT);
  endfunction

  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && pwrite;
  assign pready  = 1'b1;
  assign pslverr = apb_acc && !addr_known(paddr);
  assign seq_wr  = apb_wr && (paddr == iccf_pkg::ADDR_SEQ);

  // Output register slot is free when empty or being drained
  logic slot_free;
  assign slot_free  = !out_valid || out_ready;
  assign hdr_take   = (state_q == iccf_pkg::ICCF_HDR) && slot_free;
  assign pay_take   = (state_q == iccf_pkg::ICCF_PAY) && slot_free && in_valid;
  assign in_ready   = (state_q == iccf_pkg::ICCF_PAY) && slot_free;
  assign frame_done = pay_take && in_last;

  iccf_hdr_rom u_rom (
    .idx       (idx_q),
    .dir       (dir_q),
    .ice       (ice_q),
    .len       (len_q),
    .seq       (seq_q),
    .gw_id     (gw_id_q),
    .charge_id (charge_q),
    .octet     (hdr_octet)
  );

  // Frame sequencing; a new header only starts on a first byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= iccf_pkg::ICCF_IDLE;
      idx_q   <= 5'h00;
    end else begin
      unique case (state_q)
        iccf_pkg::ICCF_IDLE: begin
          if (en_q && in_valid && in_first) begin
            state_q <= iccf_pkg::ICCF_HDR;
            idx_q   <= 5'h00;
          end
        end
        iccf_pkg::ICCF_HDR: begin
          if (hdr_take) begin
            if (idx_q == iccf_pkg::IDX_LAST) begin
              state_q <= iccf_pkg::ICCF_PAY;
            end
            idx_q <= idx_q + 5'h01;
          end
        end
        iccf_pkg::ICCF_PAY: begin
          if (frame_done) begin
            state_q <= iccf_pkg::ICCF_IDLE;
          end
        end
        default: begin
          state_q <= iccf_pkg::ICCF_IDLE;
        end
      endcase
    end
  end

  // Packet attributes latched in idle when an enabled first byte starts the header
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      len_q    <= 16'h0000;
      dir_q    <= iccf_pkg::DIR_DOWNLINK;
      charge_q <= 32'h00000000;
    end else if (state_q == iccf_pkg::ICCF_IDLE && en_q && in_valid &&
                 in_first) begin
      len_q    <= in_len;
      dir_q    <= in_dir;
      charge_q <= in_charge_id;
    end
  end

  // Sequence counter; software may reload it, frame end has priority
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_q <= iccf_pkg::SEQ_RESET;
    end else if (frame_done) begin
      seq_q <= seq_q + 16'h0001;
    end else if (seq_wr) begin
      seq_q <= pwdata[15:0];
    end
  end

  // Output stage registered; payload copied byte for byte
  always_comb begin
    out_data_d = out_data;
    out_last_d = out_last;
    if (hdr_take) begin
      out_data_d = hdr_octet;
      out_last_d = 1'b0;
    end else if (pay_take) begin
      out_data_d = in_data;
      out_last_d = in_last;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_last  <= 1'b0;
    end else begin
      if (hdr_take || pay_take) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      out_data <= out_data_d;
      out_last <= out_last_d;
    end
  end

  // Control and identity registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q    <= 1'b0;
      ice_q   <= iccf_pkg::ICE_GATEWAY;
      gw_id_q <= iccf_pkg::GWID_RESET;
    end else if (apb_wr) begin
      if (paddr == iccf_pkg::ADDR_CTRL) begin
        en_q  <= pwdata[iccf_pkg::CTRL_EN_BIT];
        ice_q <= pwdata[iccf_pkg::CTRL_ICE_BIT];
      end
      if (paddr == iccf_pkg::ADDR_GWID) begin
        gw_id_q <= pwdata;
      end
    end
  end

  // Frame counter; clear loses to a simultaneous frame end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 32'h00000000;
    end else if (frame_done) begin
      count_q <= count_q + 32'h00000001;
    end else if (apb_wr && paddr == iccf_pkg::ADDR_CTRL &&
                 pwdata[iccf_pkg::CTRL_RST_BIT]) begin
      count_q <= 32'h00000000;
    end
  end

  // Read data registered on the setup cycle so it is valid in access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        iccf_pkg::ADDR_CTRL:  prdata <= {29'h0, 1'b0, ice_q, en_q};
        iccf_pkg::ADDR_GWID:  prdata <= gw_id_q;
        iccf_pkg::ADDR_SEQ:   prdata <= {16'h0000, seq_q};
        iccf_pkg::ADDR_STAT:  prdata <= {30'h0, state_q};
        iccf_pkg::ADDR_COUNT: prdata <= count_q;
        default:              prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// *** logic/iccf_pkg.sv ***
// Constants for the correlation header framer
package iccf_pkg;
  localparam int unsigned HDR_OCTETS   = 20;
  localparam int unsigned LEN_W        = 16;
  localparam int unsigned SEQ_W        = 16;
  localparam logic [2:0]  VERSION_V0   = 3'h0;
  localparam logic        OCT1_BIT5    = 1'h1;
  localparam logic        OCT1_SPARE   = 1'h1;
  localparam logic        OCT1_BIT1    = 1'h0;
  localparam logic [7:0]  MSG_TYPE_TPU = 8'hFF;
  localparam logic [7:0]  UNUSED_ZERO  = 8'h00;
  localparam logic [7:0]  UNUSED_ONES  = 8'hFF;
  localparam logic        DIR_UPLINK   = 1'h1;
  localparam logic        DIR_DOWNLINK = 1'h0;
  localparam logic        ICE_GATEWAY  = 1'h0;
  localparam logic        ICE_SERVING  = 1'h1;
  localparam logic [SEQ_W-1:0] SEQ_RESET = 16'h0000;
  localparam logic [4:0]  IDX_LAST     = 5'h13;
  // APB register byte addresses
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_GWID    = 8'h04;
  localparam logic [7:0]  ADDR_SEQ     = 8'h08;
  localparam logic [7:0]  ADDR_STAT    = 8'h0C;
  localparam logic [7:0]  ADDR_COUNT   = 8'h10;
  // Control register fields
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_ICE_BIT = 1;
  localparam int unsigned CTRL_RST_BIT = 2;
  localparam logic [31:0] GWID_RESET   = 32'h00000000;
  typedef enum logic [1:0] {
    ICCF_IDLE,
    ICCF_HDR,
    ICCF_PAY
  } iccf_state_e;
endpackage

// *** logic/iccf_hdr_rom.sv ***
// Header octet selector for the correlation header
`timescale 1ns/1ps
module iccf_hdr_rom (
  input  wire logic [4:0]  idx,
  input  wire logic        dir,
  input  wire logic        ice,
  input  wire logic [15:0] len,
  input  wire logic [15:0] seq,
  input  wire logic [31:0] gw_id,
  input  wire logic [31:0] charge_id,
  output logic      [7:0]  octet
);
  always_comb begin
    octet = iccf_pkg::UNUSED_ZERO;
    unique case (idx)
      5'h00: octet = {iccf_pkg::VERSION_V0, iccf_pkg::OCT1_BIT5,
                      iccf_pkg::OCT1_SPARE, ice, dir,
                      iccf_pkg::OCT1_BIT1};
      5'h01: octet = iccf_pkg::MSG_TYPE_TPU;
      5'h02: octet = len[15:8];
      5'h03: octet = len[7:0];
      5'h04: octet = seq[15:8];
      5'h05: octet = seq[7:0];
      5'h06: octet = iccf_pkg::UNUSED_ZERO;
      5'h07: octet = iccf_pkg::UNUSED_ZERO;
      5'h08: octet = iccf_pkg::UNUSED_ONES;
      5'h09: octet = iccf_pkg::UNUSED_ONES;
      5'h0A: octet = iccf_pkg::UNUSED_ONES;
      5'h0B: octet = iccf_pkg::UNUSED_ONES;
      5'h0C: octet = gw_id[31:24];
      5'h0D: octet = gw_id[23:16];
      5'h0E: octet = gw_id[15:8];
      5'h0F: octet = gw_id[7:0];
      5'h10: octet = charge_id[31:24];
      5'h11: octet = charge_id[23:16];
      5'h12: octet = charge_id[15:8];
      5'h13: octet = charge_id[7:0];
      default: octet = iccf_pkg::UNUSED_ZERO;
    endcase
  end
endmodule

// *** tb/iccf_framer_properties.sv ***
// Port assertions for the correlation header framer
`timescale 1ns/1ps
module iccf_framer_checker (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       in_valid,
  input wire logic       in_ready,
  input wire logic [7:0] in_data,
  input wire logic       in_last,
  input wire logic       out_valid,
  input wire logic       out_ready,
  input wire logic [7:0] out_data,
  input wire logic       out_last
);
  logic [4:0] idx_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Octet position in message, saturates once header is out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      idx_q <= 5'h00;
    else if (out_valid && out_ready && out_last)
      idx_q <= 5'h00;
    else if (out_valid && out_ready && idx_q != 5'h14)
      idx_q <= idx_q + 5'h01;
  end
  a_version_zero: assert property (
    out_valid && idx_q == 5'h00 |-> out_data[7:5] == 3'h0)
    else $error("version field not zero");
  a_fixed_bits: assert property (
    out_valid && idx_q == 5'h00 |-> out_data[4:3] == 2'h3 && !out_data[0])
    else $error("fixed bits of first octet wrong");
  a_msg_type: assert property (
    out_valid && idx_q == 5'h01 |-> out_data == 8'hFF)
    else $error("message type not 255");
  a_unused_zero: assert property (
    out_valid && idx_q inside {5'h06, 5'h07} |-> out_data == 8'h00)
    else $error("unused octet not zero");
  a_unused_ones: assert property (
    out_valid && idx_q inside {[5'h08:5'h0B]} |-> out_data == 8'hFF)
    else $error("unused octet not 255");
  a_hdr_no_last: assert property (
    out_valid && idx_q < 5'h14 |-> !out_last)
    else $error("message ends inside header");
  a_pay_copy: assert property (
    in_valid && in_ready |=> out_valid && out_data == $past(in_data)
      && out_last == $past(in_last))
    else $error("payload byte not copied");
  a_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data)
      && $stable(out_last))
    else $error("output changed while stalled");
  c_frame_end: cover property (out_valid && out_ready && out_last);
  c_stall: cover property (out_valid && !out_ready);
  c_take: cover property (in_valid && in_ready);
endmodule
bind iccf_framer iccf_framer_checker iccf_framer_checker_inst (.clk,
  .rst_b, .in_valid, .in_ready, .in_data, .in_last, .out_valid,
  .out_ready, .out_data, .out_last);

// *** tb/iccf_transport_sink.sv ***
// Transport sink model that takes framed messages
`timescale 1ns/1ps
module iccf_transport_sink (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       slow,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output logic            out_ready
);
  logic [7:0] msg[$];
  int         msgs;
  // Random stalls, since a real stack pushes back
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_ready <= 1'b0;
      msgs = 0;
    end else begin
      if (out_valid && out_ready) begin
        msg.push_back(out_data);
        msgs += int'(out_last);
      end
      out_ready <= slow ? 1'($urandom) : 1'b1;
    end
  end
endmodule

// *** tb/tb_intercept_cc_header_framer.sv ***
// Random and corner frames through the correlation header framer
`timescale 1ns/1ps
module tb_intercept_cc_header_framer;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic        in_valid, in_ready, in_first, in_last, in_dir, ice, slow;
  logic        out_valid, out_ready, out_last;
  logic [7:0]  paddr, in_data, out_data;
  logic [15:0] in_len, seq_e;
  logic [31:0] pwdata, prdata, in_charge_id, rd, gw;
  logic [7:0]  pay[$];
  int          fails, samples_checked, frames;
  iccf_framer iccf_framer_inst (.clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_ready,
    .in_data, .in_first, .in_last, .in_len, .in_dir, .in_charge_id,
    .out_valid, .out_ready, .out_data, .out_last);
  iccf_transport_sink iccf_transport_sink_inst (.clk, .rst_b, .slow,
    .out_valid, .out_data, .out_last, .out_ready);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task summarize;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function logic [159:0] hdr(logic d, logic c, logic [15:0] l, s);
    return {3'h0, 2'h3, c, d, 1'h0, 8'hFF, l, s, 48'h0000FFFFFFFF,
            gw, in_charge_id};
  endfunction
  task frame(input int n);
    logic [159:0] hv, he;
    in_dir <= 1'($urandom);
    in_len <= 16'(n);
    in_charge_id <= $urandom;
    slow <= 1'($urandom);
    for (int b = 0; b < n; b++) begin
      pay.push_back(8'($urandom));
      in_valid <= 1'b1;
      in_first <= (b == 0);
      in_last <= (b == n - 1);
      in_data <= pay[b];
      do @(posedge clk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    for (int t = 0; t < 400 && iccf_transport_sink_inst.msgs == frames;
         t++) @(posedge clk);
    frames++;
    chk(iccf_transport_sink_inst.msg.size() == 20 + n, "size");
    for (int i = 0; i < 20; i++)
      hv = {hv[151:0], iccf_transport_sink_inst.msg[i]};
    he = hdr(in_dir, ice, in_len, seq_e);
    chk(hv[159:64] === he[159:64], "hdr");
    chk(hv[63:0] === {gw, in_charge_id}, "corr");
    for (int i = 0; i < n; i++)
      chk(iccf_transport_sink_inst.msg[20 + i] === pay[i], "pay");
    iccf_transport_sink_inst.msg.delete();
    pay.delete();
    seq_e++;
  endtask
  initial begin
    {psel, penable, pwrite, in_valid, in_first, in_last, in_dir} = '0;
    {paddr, pwdata, in_data, in_len, in_charge_id, slow} = '0;
    {fails, samples_checked, frames, seq_e, ice} = '0;
    rst_b = 1'b0;
    void'($urandom(94841));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    gw = $urandom;
    apb(1'b1, iccf_pkg::ADDR_GWID, gw);
    apb(1'b0, 8'h24, 32'h00000000);
    chk(err === 1'b1 && rd === 32'h00000000, "unmapped read");
    for (int f = 0; f < 10; f++) begin
      ice = 1'($urandom);
      apb(1'b1, iccf_pkg::ADDR_CTRL, {30'h0, ice, 1'b1});
      if (f == 5) begin
        apb(1'b1, iccf_pkg::ADDR_SEQ, 32'h0000FFFE);
        seq_e = 16'hFFFE;
      end
      frame(f == 0 ? 1 : 1 + int'($urandom % 40));
    end
    apb(1'b0, iccf_pkg::ADDR_COUNT, 32'h00000000);
    chk(rd === 32'h0000000A, "frame count");
    apb(1'b0, iccf_pkg::ADDR_SEQ, 32'h00000000);
    chk(rd[15:0] === seq_e, "sequence after wrap");
    // Clear the frame count and disable framing in one write
    apb(1'b1, iccf_pkg::ADDR_CTRL, {29'h0, 1'b1, ice, 1'b0});
    apb(1'b0, iccf_pkg::ADDR_COUNT, 32'h00000000);
    chk(rd === 32'h00000000, "count clear");
    apb(1'b0, iccf_pkg::ADDR_CTRL, 32'h00000000);
    chk(rd === {30'h0, ice, 1'b0} && err === 1'b0, "ctrl read");
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    chk(err === 1'b1, "unmapped write");
    apb(1'b0, iccf_pkg::ADDR_GWID, 32'h00000000);
    chk(rd === gw, "gateway read");
    // Disabled framer must leave an offered first byte alone
    in_valid <= 1'b1;
    in_first <= 1'b1;
    repeat (30) begin
      @(posedge clk);
      chk(in_ready === 1'b0 && out_valid === 1'b0, "disabled");
    end
    in_valid <= 1'b0;
    apb(1'b0, iccf_pkg::ADDR_STAT, 32'h00000000);
    chk(rd === 32'h00000000, "idle state");
    apb(1'b1, iccf_pkg::ADDR_CTRL, {30'h0, ice, 1'b1});
    frame(3);
    apb(1'b0, iccf_pkg::ADDR_COUNT, 32'h00000000);
    chk(rd === 32'h00000001, "count after clear");
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
